// ===== logic/ccr_regs.sv
// charger mode control registers a and b with their derived controls
// assumes the serial front end gives one-cycle write strobes and reads
// the data word combinationally addressed; lock and strap inputs are
// stable at the release of reset
//
// Operation
// - global off forces both gate drives low
// - reverse bit enables reverse power delivery
// - bit five disables reverse pulse skipping
// - bit four disables forward pulse skipping
// - wake bit selects one second or 15ms
// - bit two disables precharge linear mode
// - bit one disables reverse audio guard
// - bit zero disables forward audio guard
// - input two drive locked off if absent
// - input one drive locked off if absent
// - frequency select; reset value from strap pin
// - bit four of b disables indicator pin
// - bit three of b disables rail hiccup
// - bit two of b disables undervolt hiccup
`timescale 1ns/1ps
module ccr_regs
  import ccr_pkg::*;
#(
  parameter longint WAKE_LONG_CYC  = ccr_pkg::CCR_WAKE_LONG_CYC,
  parameter longint WAKE_SHORT_CYC = ccr_pkg::CCR_WAKE_SHORT_CYC
) (
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  input  wire logic       reg_reset_i,
  input  wire logic       watchdog_expired_i,
  input  wire logic [7:0] addr_i,
  input  wire logic       wr_en_i,
  input  wire logic [7:0] wr_data_i,
  output logic      [7:0] rd_data_o,
  input  wire logic       strap_config_pin_i,
  input  wire logic       input1_fitted_i,
  input  wire logic       input2_fitted_i,
  input  wire logic       wake_button_pin_n_i,
  output logic            gate_drive_global_off_o,
  output logic            input1_gate_drive_on_o,
  output logic            input2_gate_drive_on_o,
  output logic            reverse_power_on_o,
  output logic            reverse_pulse_skip_off_o,
  output logic            forward_pulse_skip_off_o,
  output logic            ship_wake_hold_select_o,
  output logic            precharge_linear_mode_off_o,
  output logic            reverse_audio_guard_off_o,
  output logic            forward_audio_guard_off_o,
  output logic            switching_frequency_select_o,
  output logic            indicator_pin_off_o,
  output logic            rail_short_hiccup_off_o,
  output logic            reverse_undervolt_hiccup_off_o,
  output logic            ship_wake_o
);
  import ccr_pkg::*;

  // ********************************************************************
  // power-on capture of straps and fitted switches
  // ********************************************************************
  ccr_state_t state_q;
  logic       strap_q;
  logic       in1_ok_q;
  logic       in2_ok_q;

  // caught by the clock after release so no port feeds a reset value
  // fitted levels are looked at once only; a later change on those pins
  // cannot unlock a drive that power-on found absent
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_q <= CCR_ST_INIT;
    end else begin
      case (state_q)
        CCR_ST_INIT: state_q <= CCR_ST_RUN;
        CCR_ST_RUN:  state_q <= CCR_ST_RUN;
        default:     state_q <= CCR_ST_INIT;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      strap_q  <= 1'b0;
      in1_ok_q <= 1'b0;
      in2_ok_q <= 1'b0;
    end else if (state_q == CCR_ST_INIT) begin
      strap_q  <= strap_config_pin_i;
      in1_ok_q <= input1_fitted_i;
      in2_ok_q <= input2_fitted_i;
    end
  end

  // ********************************************************************
  // register a
  // ********************************************************************
  logic [7:0] ctl_a_q;
  logic [7:0] ctl_b_q;
  logic       wr_a;
  logic       wr_b;

  logic       run;

  // ********************************************************************
  // write decode
  // ********************************************************************
  // writes in the capture cycle are refused so the strap load wins
  assign run  = (state_q == CCR_ST_RUN);
  assign wr_a = wr_en_i && run && (addr_i == CCR_ADDR_A);
  assign wr_b = wr_en_i && run && (addr_i == CCR_ADDR_B);

  // watchdog clears selected bits, register reset clears all
  // watchdog outranks a write in the same cycle: host has lost control
  always_ff @(posedge clk_i) begin
    if (reset_i || reg_reset_i) begin
      ctl_a_q <= CCR_RESET_A;
    end else if (watchdog_expired_i) begin
      ctl_a_q <= ctl_a_q & ~CCR_WD_MASK_A;
    end else if (wr_a) begin
      ctl_a_q <= wr_data_i;
    end
  end

  // ********************************************************************
  // register b
  // ********************************************************************
  logic [7:0] wr_b_val;
  logic       gate_off;

  // bit seven has no watchdog clear, so drives stay blocked on expiry
  assign gate_off = ctl_a_q[CCR_A_GATE_OFF];

  // lock gate drives when off or not fitted
  always_comb begin
    wr_b_val = wr_data_i & CCR_RW_MASK_B;
    if (gate_off || !in2_ok_q) begin
      wr_b_val[CCR_B_IN2_ON] = 1'b0;
    end
    if (gate_off || !in1_ok_q) begin
      wr_b_val[CCR_B_IN1_ON] = 1'b0;
    end
  end

  // frequency reset value loaded from the strap at power-on
  // register reset keeps strap value of frequency select
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ctl_b_q <= CCR_RESET_B;
    end else if (state_q == CCR_ST_INIT || reg_reset_i) begin
      ctl_b_q <= CCR_RESET_B;
      ctl_b_q[CCR_B_FREQ_SEL] <= (state_q == CCR_ST_INIT) ?
                                 strap_config_pin_i : strap_q;
    end else if (watchdog_expired_i) begin
      ctl_b_q <= ctl_b_q & ~CCR_WD_MASK_B;
    end else if (wr_b) begin
      ctl_b_q <= wr_b_val;
    end else if (gate_off) begin
      // setting the global off also clears stored enables
      ctl_b_q[CCR_B_IN2_ON] <= 1'b0;
      ctl_b_q[CCR_B_IN1_ON] <= 1'b0;
    end
  end

  // ********************************************************************
  // readback and outputs
  // ********************************************************************
  // unmapped offsets read zero so a stray poll sees idle fields
  always_comb begin
    case (addr_i)
      CCR_ADDR_A: rd_data_o = ctl_a_q;
      CCR_ADDR_B: rd_data_o = ctl_b_q;
      default:    rd_data_o = 8'h00;
    endcase
  end


  // ********************************************************************
  // field outputs
  // ********************************************************************
  // fields leave straight from the register bits; only the gate drives
  // pass through logic, and that logic only ever forces them low
  assign gate_drive_global_off_o      = gate_off;
  // gated again so a same-cycle set never leaks a drive
  assign input1_gate_drive_on_o       = ctl_b_q[CCR_B_IN1_ON] && !gate_off;
  assign input2_gate_drive_on_o       = ctl_b_q[CCR_B_IN2_ON] && !gate_off;
  assign reverse_power_on_o           = ctl_a_q[CCR_A_REV_ON];
  assign reverse_pulse_skip_off_o     = ctl_a_q[CCR_A_REV_PSK_OFF];
  assign forward_pulse_skip_off_o     = ctl_a_q[CCR_A_FWD_PSK_OFF];
  assign ship_wake_hold_select_o      = ctl_a_q[CCR_A_WAKE_SEL];
  assign precharge_linear_mode_off_o  = ctl_a_q[CCR_A_LIN_OFF];
  assign reverse_audio_guard_off_o    = ctl_a_q[CCR_A_REV_AUD_OFF];
  assign forward_audio_guard_off_o    = ctl_a_q[CCR_A_FWD_AUD_OFF];
  assign switching_frequency_select_o = ctl_b_q[CCR_B_FREQ_SEL];
  assign indicator_pin_off_o          = ctl_b_q[CCR_B_IND_OFF];
  assign rail_short_hiccup_off_o      = ctl_b_q[CCR_B_RAIL_HIC];
  assign reverse_undervolt_hiccup_off_o = ctl_b_q[CCR_B_UV_HIC];


  // ********************************************************************
  // wake hold timer
  // ********************************************************************
  // the count restarts on every release, so a bouncing pin waits again
  // hold time chosen by the wake select bit
  ccr_wake_timer #(
    .LONG_CYC  (WAKE_LONG_CYC),
    .SHORT_CYC (WAKE_SHORT_CYC)
  ) u_wake (
    .clk_i               (clk_i),
    .reset_i             (reset_i),
    .wake_button_pin_n_i (wake_button_pin_n_i),
    .short_sel_i         (ctl_a_q[CCR_A_WAKE_SEL]),
    .wake_o              (ship_wake_o)
  );
endmodule : ccr_regs

// ===== logic/ccr_pkg.sv
// package for the charger mode control register pair
// assumes an 8-bit register access port from the serial front end
package ccr_pkg;
  localparam logic [7:0] CCR_ADDR_A    = 8'h12;
  localparam logic [7:0] CCR_ADDR_B    = 8'h13;
  localparam logic [7:0] CCR_RESET_A   = 8'h00;
  localparam logic [7:0] CCR_RESET_B   = 8'h00;
  // control a field positions
  localparam int CCR_A_GATE_OFF    = 7;
  localparam int CCR_A_REV_ON      = 6;
  localparam int CCR_A_REV_PSK_OFF = 5;
  localparam int CCR_A_FWD_PSK_OFF = 4;
  localparam int CCR_A_WAKE_SEL    = 3;
  localparam int CCR_A_LIN_OFF     = 2;
  localparam int CCR_A_REV_AUD_OFF = 1;
  localparam int CCR_A_FWD_AUD_OFF = 0;
  // control b field positions
  localparam int CCR_B_IN2_ON      = 7;
  localparam int CCR_B_IN1_ON      = 6;
  localparam int CCR_B_FREQ_SEL    = 5;
  localparam int CCR_B_IND_OFF     = 4;
  localparam int CCR_B_RAIL_HIC    = 3;
  localparam int CCR_B_UV_HIC      = 2;
  // bits of control a cleared on watchdog expiry
  localparam logic [7:0] CCR_WD_MASK_A = 8'h66;
  // bits of control b cleared on watchdog expiry
  localparam logic [7:0] CCR_WD_MASK_B = 8'h10;
  // writable bits of control b (low two belong elsewhere)
  localparam logic [7:0] CCR_RW_MASK_B = 8'hFC;
  // wake hold times
  localparam int CCR_WAKE_LONG_MS  = 1000;
  localparam int CCR_WAKE_SHORT_MS = 15;
  localparam int CCR_CLK_KHZ       = 100000;
  localparam longint CCR_WAKE_LONG_CYC =
    longint'(CCR_WAKE_LONG_MS) * CCR_CLK_KHZ;
  localparam longint CCR_WAKE_SHORT_CYC =
    longint'(CCR_WAKE_SHORT_MS) * CCR_CLK_KHZ;
  // switching frequency codes
  localparam logic CCR_FREQ_HIGH = 1'b0;
  localparam logic CCR_FREQ_LOW  = 1'b1;
  typedef enum logic [1:0] {CCR_ST_INIT, CCR_ST_RUN} ccr_state_t;
endpackage : ccr_pkg

// ===== logic/ccr_wake_timer.sv
// ship-mode wake hold timer: counts how long the wake pin is held low
// assumes the wake pin is already synchronous to clk_i
`timescale 1ns/1ps
module ccr_wake_timer #(
  parameter longint LONG_CYC  = 100000000,
  parameter longint SHORT_CYC = 1500000
) (
  input  wire logic clk_i,
  input  wire logic reset_i,
  input  wire logic wake_button_pin_n_i,
  input  wire logic short_sel_i,
  output logic      wake_o
);
  logic [31:0] cnt_q;
  logic [31:0] limit;

  assign limit = short_sel_i ? SHORT_CYC[31:0] : LONG_CYC[31:0];

  // count while held low, restart on release
  always_ff @(posedge clk_i) begin
    if (reset_i || wake_button_pin_n_i) begin
      cnt_q <= 32'h0;
    end else if (cnt_q < limit) begin
      cnt_q <= cnt_q + 32'h1;
    end
  end

  // one pulse when the hold time is reached
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      wake_o <= 1'b0;
    end else begin
      wake_o <= !wake_button_pin_n_i && (cnt_q == limit - 32'h1);
    end
  end
endmodule : ccr_wake_timer

// ===== bench/ccr_regs_props.sv
// assertions on the control register pair, ports of ccr_regs only
// assumes straps and fitted levels stay put after reset
`timescale 1ns/1ps
module ccr_regs_props (
  input wire logic       clk_i,
  input wire logic       reset_i,
  input wire logic       reg_reset_i,
  input wire logic       watchdog_expired_i,
  input wire logic [7:0] addr_i,
  input wire logic       wr_en_i,
  input wire logic [7:0] wr_data_i,
  input wire logic       strap_config_pin_i,
  input wire logic       input1_fitted_i,
  input wire logic       input2_fitted_i,
  input wire logic       gate_drive_global_off_o,
  input wire logic       input1_gate_drive_on_o,
  input wire logic       input2_gate_drive_on_o,
  input wire logic       reverse_power_on_o,
  input wire logic       reverse_pulse_skip_off_o,
  input wire logic       forward_pulse_skip_off_o,
  input wire logic       precharge_linear_mode_off_o,
  input wire logic       reverse_audio_guard_off_o,
  input wire logic       indicator_pin_off_o,
  input wire logic       switching_frequency_select_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // ****************
  // properties
  // ****************
  a_glob_gates_off: assert property (
    gate_drive_global_off_o |->
      !input1_gate_drive_on_o && !input2_gate_drive_on_o)
    else $error("gate drive on while global off");
  a_fit1_lock: assert property (
    !input1_fitted_i |-> !input1_gate_drive_on_o)
    else $error("absent input one driven");
  a_fit2_lock: assert property (
    !input2_fitted_i |-> !input2_gate_drive_on_o)
    else $error("absent input two driven");
  a_rev_write: assert property (
    wr_en_i && addr_i == 8'h12 && !watchdog_expired_i && !reg_reset_i
      |=> reverse_power_on_o == $past(wr_data_i[6]))
    else $error("reverse enable not written");
  a_ind_write: assert property (
    wr_en_i && addr_i == 8'h13 && !watchdog_expired_i && !reg_reset_i
      |=> indicator_pin_off_o == $past(wr_data_i[4]))
    else $error("indicator disable not written");
  a_wd_clears: assert property (
    watchdog_expired_i |=> !reverse_power_on_o && !indicator_pin_off_o
      && !reverse_pulse_skip_off_o && !precharge_linear_mode_off_o
      && !reverse_audio_guard_off_o)
    else $error("watchdog left a field set");
  a_fwd_psk_kept: assert property (
    watchdog_expired_i && !reg_reset_i |=> $stable(forward_pulse_skip_off_o))
    else $error("watchdog touched forward pulse skip");
  a_regrst_strap: assert property (
    reg_reset_i |=> switching_frequency_select_o == $past(strap_config_pin_i))
    else $error("frequency not back to strap");
  a_regrst_clear: assert property (
    reg_reset_i |=> !reverse_power_on_o && !forward_pulse_skip_off_o)
    else $error("register reset left a field set");
endmodule : ccr_regs_props

bind ccr_regs ccr_regs_props u_props (.clk_i, .reset_i, .reg_reset_i,
  .watchdog_expired_i, .addr_i, .wr_en_i, .wr_data_i, .strap_config_pin_i,
  .input1_fitted_i, .input2_fitted_i, .gate_drive_global_off_o,
  .input1_gate_drive_on_o, .input2_gate_drive_on_o, .reverse_power_on_o,
  .reverse_pulse_skip_off_o, .forward_pulse_skip_off_o,
  .precharge_linear_mode_off_o, .reverse_audio_guard_off_o,
  .indicator_pin_off_o, .switching_frequency_select_o);

// ===== bench/ccr_regs_test.sv
// self-checking bench for ccr_regs
// input one absent, input two fitted, strap high; short wake counts
`timescale 1ns/1ps
module ccr_regs_test;
  import ccr_pkg::*;
  logic clk = 0, rst = 1, rr = 0, wd = 0, we = 0, wk = 1, pulse;
  logic [7:0] addr = 8'h00, wdat = 8'h00, rd, ao;
  logic [7:2] bo;
  int err_count = 0, num_checks = 0;
  always #5 clk = ~clk;
  ccr_regs #(.WAKE_LONG_CYC(20), .WAKE_SHORT_CYC(5)) dut (
    .clk_i(clk), .reset_i(rst), .reg_reset_i(rr), .watchdog_expired_i(wd),
    .addr_i(addr), .wr_en_i(we), .wr_data_i(wdat), .rd_data_o(rd),
    .strap_config_pin_i(1'b1), .input1_fitted_i(1'b0),
    .input2_fitted_i(1'b1), .wake_button_pin_n_i(wk),
    .gate_drive_global_off_o(ao[7]), .reverse_power_on_o(ao[6]),
    .reverse_pulse_skip_off_o(ao[5]), .forward_pulse_skip_off_o(ao[4]),
    .ship_wake_hold_select_o(ao[3]), .precharge_linear_mode_off_o(ao[2]),
    .reverse_audio_guard_off_o(ao[1]), .forward_audio_guard_off_o(ao[0]),
    .input2_gate_drive_on_o(bo[7]), .input1_gate_drive_on_o(bo[6]),
    .switching_frequency_select_o(bo[5]), .indicator_pin_off_o(bo[4]),
    .rail_short_hiccup_off_o(bo[3]),
    .reverse_undervolt_hiccup_off_o(bo[2]), .ship_wake_o(pulse));
  // ****************
  // shared tasks
  // ****************
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdat = d;
    we = 1;
    @(negedge clk);
    we = 0;
  endtask : wr
  // read back and compare the field outputs too
  task automatic rb(logic [7:0] a, logic [7:0] e);
    @(negedge clk);
    addr = a;
    #1;
    chk("read", e, rd);
    if (a == CCR_ADDR_A) chk("outs a", e, ao);
    if (a == CCR_ADDR_B) chk("outs b", e, {bo, 2'b00});
  endtask : rb
  // pin held low from now; pulse must land in lo..hi cycles
  task automatic wake(int lo, int hi);
    int n;
    n = 0;
    @(negedge clk);
    wk = 0;
    while (n < 40 && pulse !== 1'b1) begin
      @(posedge clk);
      #1;
      n++;
    end
    @(negedge clk);
    wk = 1;
    chk("wake ok", 8'h01, {7'h00, n >= lo && n <= hi});
    repeat (3) @(negedge clk);
  endtask : wake
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_of_test
  initial begin
    #100000;
    err_count++;
    end_of_test();
  end
  // ****************
  // scenarios
  // ****************
  initial begin
    repeat (20) @(negedge clk);
    rst = 0;
    rb(8'h12, 8'h00);
    rb(8'h13, 8'h20);
    rb(8'h14, 8'h00);
    $display("reset values done");
    for (int i = 0; i < 7; i++) begin
      wr(8'h12, 8'h01 << i);
      rb(8'h12, 8'h01 << i);
    end
    $display("control a fields done");
    wr(8'h13, 8'hFF);
    rb(8'h13, 8'hBC);
    wr(8'h12, 8'h80);
    rb(8'h12, 8'h80);
    rb(8'h13, 8'h3C);
    wr(8'h12, 8'h00);
    wr(8'h13, 8'h80);
    rb(8'h13, 8'h80);
    $display("gate drives done");
    wr(8'h12, 8'h7F);
    wr(8'h13, 8'h3C);
    @(negedge clk);
    wd = 1;
    we = 1;
    addr = 8'h12;
    wdat = 8'h40;
    @(negedge clk);
    wd = 0;
    we = 0;
    rb(8'h12, 8'h19);
    rb(8'h13, 8'h2C);
    $display("watchdog done");
    wr(8'h13, 8'h0C);
    @(negedge clk);
    rr = 1;
    @(negedge clk);
    rr = 0;
    rb(8'h12, 8'h00);
    rb(8'h13, 8'h20);
    $display("register reset done");
    wr(8'h12, 8'h08);
    wake(4, 8);
    wr(8'h12, 8'h00);
    wake(19, 23);
    $display("wake hold done");
    end_of_test();
  end
endmodule : ccr_regs_test
